//--- rtl/vpf_formatter.sv
// Pixel output formatter: register side on mclk, pixel bus side on the full-rate clock
`include "vpf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module vpf_formatter (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic full_rate_clock,
   input wire vpf_pkg::vpf_pixel_type src_pixel,
   input wire vpf_pkg::vpf_timing_type src_timing,
   output logic [15:0] pixel_bus,
   output logic half_rate_clock,
   output logic line_sync_out,
   output logic field_sync_out,
   output logic active_out,
   output logic field_id_out
);

   // Saturate a byte into a closed range
   function automatic logic [7:0] vpf_clip(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
      logic [7:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   // ---------------- Register side (mclk) ----------------
   logic [7:0] ofc_q;
   logic [7:0] pol_q;
   logic [9:0] hd_q;
   logic [9:0] ha_q;
   logic [7:0] rdata_q;
   logic dirty_q;
   logic req_q;
   logic ack_s;
   logic fid_s;
   logic launch;
   vpf_pkg::vpf_cfg_type cfg_live;
   vpf_pkg::vpf_cfg_type snap_q;

   // Writes decode on the documented register offset and the auxiliary ones
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ofc_q <= `VPF_OFC_RESET;
         pol_q <= `VPF_POL_RESET;
         hd_q <= `VPF_HD_RESET;
         ha_q <= `VPF_HA_RESET;
      end else if (reg_wr) begin
         if (reg_addr == `VPF_OFC_ADDR) begin
            ofc_q <= reg_wdata;
         end else if (reg_addr == `VPF_POL_ADDR) begin
            pol_q <= reg_wdata;
         end else if (reg_addr == `VPF_HDL_ADDR) begin
            hd_q[7:0] <= reg_wdata;
         end else if (reg_addr == `VPF_HAL_ADDR) begin
            ha_q[7:0] <= reg_wdata;
         end else if (reg_addr == `VPF_HHI_ADDR) begin
            hd_q[9:8] <= reg_wdata[`VPF_HHI_HD_LSB +: 2];
            ha_q[9:8] <= reg_wdata[`VPF_HHI_HA_LSB +: 2];
         end
      end
   end

   // Reads answer one edge after the strobe; unmapped offsets read zero
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rdata_q <= `VPF_READ_NONE;
      end else if (reg_rd) begin
         if (reg_addr == `VPF_OFC_ADDR) begin
            rdata_q <= ofc_q;
         end else if (reg_addr == `VPF_POL_ADDR) begin
            rdata_q <= pol_q;
         end else if (reg_addr == `VPF_HDL_ADDR) begin
            rdata_q <= hd_q[7:0];
         end else if (reg_addr == `VPF_HAL_ADDR) begin
            rdata_q <= ha_q[7:0];
         end else if (reg_addr == `VPF_HHI_ADDR) begin
            rdata_q <= {4'h0, ha_q[9:8], hd_q[9:8]};
         end else if (reg_addr == `VPF_STAT_ADDR) begin
            rdata_q <= {6'h00, dirty_q | (req_q ^ ack_s), fid_s};
         end else begin
            rdata_q <= `VPF_READ_NONE;
         end
      end
   end
   assign reg_rdata = rdata_q;

   assign cfg_live = '{ofc: ofc_q, pol: pol_q, hd: hd_q, ha: ha_q};
   assign launch = dirty_q && (req_q == ack_s);

   // Snapshot handshake: the snapshot stays frozen until the link side acknowledges,
   // so the wide bundle never tears; a write during a transfer is sent afterwards
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         dirty_q <= 1'b0;
         req_q <= 1'b0;
         snap_q <= '{ofc: `VPF_OFC_RESET, pol: `VPF_POL_RESET, hd: `VPF_HD_RESET, ha: `VPF_HA_RESET};
      end else begin
         if (reg_wr) begin
            dirty_q <= 1'b1;
         end else if (launch) begin
            dirty_q <= 1'b0;
         end
         if (launch) begin
            snap_q <= cfg_live;
            req_q <= ~req_q;
         end
      end
   end

   // ---------------- Link side (full_rate_clock) ----------------
   logic lrst_n;
   logic req_s;
   logic seen_q;
   vpf_pkg::vpf_cfg_type lcfg_q;

   // Reset is brought into the link domain before any link flop uses it
   vpf_sync2 #(.W(1)) u_rst_sync (
      .clk(full_rate_clock),
      .rstn(1'b1),
      .d(resetn),
      .q(lrst_n)
   );

   vpf_sync2 #(.W(1)) u_req_sync (
      .clk(full_rate_clock),
      .rstn(lrst_n),
      .d(req_q),
      .q(req_s)
   );

   vpf_sync2 #(.W(1)) u_ack_sync (
      .clk(mclk),
      .rstn(resetn),
      .d(seen_q),
      .q(ack_s)
   );

   // Capture the frozen snapshot once the request toggle has settled here
   always_ff @(posedge full_rate_clock) begin
      if (!lrst_n) begin
         seen_q <= 1'b0;
         lcfg_q <= '{ofc: `VPF_OFC_RESET, pol: `VPF_POL_RESET, hd: `VPF_HD_RESET, ha: `VPF_HA_RESET};
      end else if (req_s != seen_q) begin
         seen_q <= req_s;
         lcfg_q <= snap_q;
      end
   end

   logic range_b;
   logic code_b;
   logic wide_b;
   logic tick;
   logic ph_q;
   logic [10:0] hcnt_q;
   logic [10:0] cur_h;
   logic [10:0] h_end;
   logic cb_q;
   logic cur_cb;
   logic line_pend_q;
   logic h_act;
   logic comp_act;
   logic before_first;
   logic after_last;
   logic [7:0] y_lo;
   logic [7:0] y_hi;
   logic [7:0] black;
   logic [7:0] y_vid;
   logic [7:0] c_vid;
   logic [7:0] y_sel;
   logic [7:0] c_sel;
   logic emit_line;
   logic [7:0] luma_hold_q;
   logic [15:0] bus_q;
   logic act_out_q;

   assign range_b = lcfg_q.ofc[`VPF_OFC_RANGE];
   assign code_b = lcfg_q.ofc[`VPF_OFC_CODE];
   assign wide_b = lcfg_q.ofc[`VPF_OFC_WIDE];
   assign tick = ph_q;

   // Half-rate clock is a divide-by-two of the full-rate clock
   always_ff @(posedge full_rate_clock) begin
      if (!lrst_n) begin
         ph_q <= 1'b0;
      end else begin
         ph_q <= ~ph_q;
      end
   end
   assign half_rate_clock = ph_q;

   // Horizontal position of the pixel taken on this tick
   assign cur_h = src_timing.line_start ? '0 : hcnt_q;
   assign h_end = {1'b0, lcfg_q.hd} + {1'b0, lcfg_q.ha};
   assign h_act = (cur_h >= {1'b0, lcfg_q.hd}) && (cur_h < h_end);
   assign comp_act = h_act && !src_timing.vblank;
   assign before_first = ((cur_h + `VPF_H_STEP) == {1'b0, lcfg_q.hd});
   assign after_last = (cur_h == h_end);
   assign cur_cb = src_timing.line_start ? 1'b1 : cb_q;

   // Pixel counter and chroma phase; phase holds over invalid pixels
   always_ff @(posedge full_rate_clock) begin
      if (!lrst_n) begin
         hcnt_q <= '0;
         cb_q <= 1'b1;
      end else if (tick) begin
         hcnt_q <= cur_h + `VPF_H_STEP;
         cb_q <= src_pixel.valid ? ~cur_cb : cur_cb;
      end
   end

   // Luma limits depend on range and on whether codes are reserved
   always_comb begin
      y_lo = `VPF_Y_LO_STD;
      y_hi = `VPF_Y_HI_STD;
      black = `VPF_BLACK_STD;
      if (range_b && code_b) begin
         y_lo = `VPF_Y_LO_CODE;
         y_hi = `VPF_Y_HI_CODE;
         black = `VPF_BLACK_FULL;
      end else if (range_b) begin
         y_lo = `VPF_Y_LO_FULL;
         y_hi = `VPF_Y_HI_FULL;
         black = `VPF_BLACK_FULL;
      end
   end

   // Blanking pixels go out as black with zero colour, active ones as video
   assign y_vid = vpf_clip(comp_act ? src_pixel.y : black, y_lo, y_hi);
   assign c_vid = vpf_clip(comp_act ? (cur_cb ? src_pixel.cb : src_pixel.cr) : `VPF_C_ZERO, `VPF_C_LO, `VPF_C_HI);
   assign emit_line = (src_timing.line_start || line_pend_q) && !src_timing.field_start;

   // Embedded code precedence: field, line, invalid, before first, after last
   always_comb begin
      y_sel = y_vid;
      c_sel = c_vid;
      if (code_b) begin
         c_sel = cur_cb ? `VPF_FLAG_CB : `VPF_FLAG_CR;
         if (src_timing.field_start) begin
            y_sel = src_timing.even_next ? `VPF_EV_FIELD_EVEN : `VPF_EV_FIELD_ODD;
         end else if (emit_line) begin
            y_sel = src_timing.vblank ? `VPF_EV_LINE_BLANK : `VPF_EV_LINE_ACT;
         end else if (!src_pixel.valid) begin
            y_sel = `VPF_EV_INVALID;
            c_sel = cur_cb ? `VPF_FLAG_CR : `VPF_FLAG_CB;
         end else if (before_first) begin
            y_sel = `VPF_EV_BEFORE_FIRST;
         end else if (after_last) begin
            y_sel = `VPF_EV_AFTER_LAST;
         end else begin
            y_sel = y_vid;
            c_sel = c_vid;
         end
      end
   end

   // A line code beaten by a field code slips to the next pixel
   always_ff @(posedge full_rate_clock) begin
      if (!lrst_n) begin
         line_pend_q <= 1'b0;
      end else if (tick && code_b) begin
         line_pend_q <= src_timing.line_start && src_timing.field_start;
      end
   end

   // Bus lanes: wide form loads both bytes per pixel, narrow form chroma then luma
   always_ff @(posedge full_rate_clock) begin
      if (!lrst_n) begin
         bus_q <= {`VPF_LANE_IDLE, `VPF_LANE_IDLE};
         luma_hold_q <= `VPF_LANE_IDLE;
      end else if (tick) begin
         luma_hold_q <= y_sel;
         if (wide_b) begin
            bus_q <= {y_sel, c_sel};
         end else begin
            bus_q <= {c_sel, `VPF_LANE_IDLE};
         end
      end else if (!wide_b) begin
         bus_q <= {luma_hold_q, `VPF_LANE_IDLE};
      end
   end
   assign pixel_bus = bus_q;

   // Active pin follows the selected window with programmable polarity
   always_ff @(posedge full_rate_clock) begin
      if (!lrst_n) begin
         act_out_q <= 1'b0;
      end else if (tick) begin
         act_out_q <= (lcfg_q.pol[`VPF_POL_ACTSEL] ? h_act : comp_act) ^ lcfg_q.pol[`VPF_POL_ACT];
      end
   end
   assign active_out = act_out_q;

   // ---------------- Sync pins ----------------
   logic [2:0] ls_cnt_q;
   logic [2:0] fs_cnt_q;
   logic [2:0] fs_wait_q;
   logic fs_arm_q;
   logic [2:0] fnum_q;
   logic fid_q;
   logic fpend_q;
   logic ls_out_q;
   logic fs_out_q;
   logic fid_out_q;

   // Line sync pulse lasts one pixel of full-rate edges
   always_ff @(posedge full_rate_clock) begin
      if (!lrst_n) begin
         ls_cnt_q <= '0;
      end else if (tick && src_timing.line_start) begin
         ls_cnt_q <= `VPF_SYNC_PULSE;
      end else if (ls_cnt_q != '0) begin
         ls_cnt_q <= ls_cnt_q - 3'h1;
      end
   end

   // Field sync; on fields 1,3,5,7 it waits so that line sync leads by two output clocks
   always_ff @(posedge full_rate_clock) begin
      if (!lrst_n) begin
         fs_cnt_q <= '0;
         fs_wait_q <= '0;
         fs_arm_q <= 1'b0;
         fnum_q <= '0;
      end else if (tick && src_timing.field_start) begin
         fnum_q <= fnum_q + 3'h1;
         if (!fnum_q[0]) begin
            fs_wait_q <= wide_b ? `VPF_FSYNC_WAIT_16 : `VPF_FSYNC_WAIT_8;
            fs_arm_q <= 1'b1;
         end else begin
            fs_cnt_q <= `VPF_SYNC_PULSE;
         end
      end else if (fs_arm_q) begin
         if (fs_wait_q == '0) begin
            fs_cnt_q <= `VPF_SYNC_PULSE;
            fs_arm_q <= 1'b0;
         end else begin
            fs_wait_q <= fs_wait_q - 3'h1;
         end
         if (fs_cnt_q != '0) begin
            fs_cnt_q <= fs_cnt_q - 3'h1;
         end
      end else if (fs_cnt_q != '0) begin
         fs_cnt_q <= fs_cnt_q - 3'h1;
      end
   end

   // Field identity changes at the end of horizontal active after a field start
   always_ff @(posedge full_rate_clock) begin
      if (!lrst_n) begin
         fid_q <= 1'b0;
         fpend_q <= 1'b0;
      end else if (tick) begin
         if (fpend_q && after_last) begin
            fid_q <= ~fid_q;
         end
         if (src_timing.field_start) begin
            fpend_q <= 1'b1;
         end else if (after_last) begin
            fpend_q <= 1'b0;
         end
      end
   end

   // Sync levels are active low by default; the polarity bits invert them
   always_ff @(posedge full_rate_clock) begin
      if (!lrst_n) begin
         ls_out_q <= 1'b1;
         fs_out_q <= 1'b1;
         fid_out_q <= 1'b0;
      end else begin
         ls_out_q <= (ls_cnt_q == '0) ^ lcfg_q.pol[`VPF_POL_LINE];
         fs_out_q <= (fs_cnt_q == '0) ^ lcfg_q.pol[`VPF_POL_FSYNC];
         fid_out_q <= fid_q ^ lcfg_q.pol[`VPF_POL_FID];
      end
   end
   assign line_sync_out = ls_out_q;
   assign field_sync_out = fs_out_q;
   assign field_id_out = fid_out_q;

   // Field identity back to the register side for status reads
   vpf_sync2 #(.W(1)) u_fid_sync (
      .clk(mclk),
      .rstn(resetn),
      .d(fid_q),
      .q(fid_s)
   );

endmodule
`default_nettype wire

//--- rtl/vpf_pkg.sv
// Types shared by the pixel output formatter
package vpf_pkg;

   // Configuration bundle handed from the register side to the link side
   typedef struct packed {
      logic [7:0] ofc;
      logic [7:0] pol;
      logic [9:0] hd;
      logic [9:0] ha;
   } vpf_cfg_type;

   // One decoded 4:2:2 pixel from the decoder core
   typedef struct packed {
      logic [7:0] y;
      logic [7:0] cb;
      logic [7:0] cr;
      logic valid;
   } vpf_pixel_type;

   // Timing from the decoder core: line and field starts one pixel wide, vblank and even_next as levels
   typedef struct packed {
      logic line_start;
      logic field_start;
      logic vblank;
      logic even_next;
   } vpf_timing_type;

endpackage

//--- rtl/vpf_regs.svh
// Register offsets, field positions, reset values, codes and timing counts of the pixel output formatter
`ifndef VPF_REGS_SVH
`define VPF_REGS_SVH

// Register offsets
`define VPF_OFC_ADDR 8'h12
`define VPF_POL_ADDR 8'h13
`define VPF_HDL_ADDR 8'h14
`define VPF_HAL_ADDR 8'h15
`define VPF_HHI_ADDR 8'h16
`define VPF_STAT_ADDR 8'h17

// Reset values
`define VPF_OFC_RESET 8'h04
`define VPF_POL_RESET 8'h00
`define VPF_HD_RESET 10'h080
`define VPF_HA_RESET 10'h2D0
`define VPF_READ_NONE 8'h00

// Field positions
`define VPF_OFC_RANGE 0
`define VPF_OFC_CODE 1
`define VPF_OFC_WIDE 2
`define VPF_POL_ACT 0
`define VPF_POL_LINE 1
`define VPF_POL_FSYNC 2
`define VPF_POL_FID 3
`define VPF_POL_ACTSEL 4
`define VPF_HHI_HD_LSB 0
`define VPF_HHI_HA_LSB 2
`define VPF_STAT_FID 0
`define VPF_STAT_BUSY 1

// Event codes carried on the luma byte, and the flags carried on the chroma byte
`define VPF_EV_INVALID 8'h00
`define VPF_EV_AFTER_LAST 8'h01
`define VPF_EV_BEFORE_FIRST 8'h02
`define VPF_EV_LINE_ACT 8'h03
`define VPF_EV_LINE_BLANK 8'h04
`define VPF_EV_FIELD_EVEN 8'h05
`define VPF_EV_FIELD_ODD 8'h06
`define VPF_FLAG_CB 8'hFF
`define VPF_FLAG_CR 8'hFE

// Level limits
`define VPF_Y_LO_STD 8'h10
`define VPF_Y_HI_STD 8'hEB
`define VPF_Y_LO_CODE 8'h10
`define VPF_Y_HI_CODE 8'hFD
`define VPF_Y_LO_FULL 8'h00
`define VPF_Y_HI_FULL 8'hFF
`define VPF_C_LO 8'h02
`define VPF_C_HI 8'hFD
`define VPF_C_ZERO 8'h80
`define VPF_BLACK_STD 8'h10
`define VPF_BLACK_FULL 8'h00
`define VPF_LANE_IDLE 8'h00

// Sync timing in full-rate clock edges, and the pixel counter step in pixels
`define VPF_SYNC_PULSE 3'h2
`define VPF_FSYNC_WAIT_8 3'h1
`define VPF_FSYNC_WAIT_16 3'h3
`define VPF_H_STEP 11'h001

`endif

//--- rtl/vpf_sync2.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module vpf_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // First stage is read only by the second stage
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule
`default_nettype wire

//--- verification/vpf_capture_model.sv
// Behavioural capture controller on the far side of the pixel bus
`timescale 1ns/1ps
`default_nettype none
module vpf_capture_model (
   input wire logic clk,
   input wire logic clear,
   input wire logic wide,
   input wire logic [15:0] pixel_bus,
   input wire logic half_rate_clock,
   output logic [15:0] code_mask
);
   logic [7:0] chroma;
   logic [7:0] luma;
   logic have;
   // Bytes are taken one edge after they settle; narrow luma follows its chroma by one edge
   always @(posedge clk) begin
      have = 1'b0;
      if (!half_rate_clock) begin
         chroma = wide ? pixel_bus[7:0] : pixel_bus[15:8];
         luma = pixel_bus[15:8];
         have = wide;
      end else if (!wide) begin
         luma = pixel_bus[15:8];
         have = 1'b1;
      end
      // A flag on either phase marks a code, so a slipped line code is still seen
      if (have && chroma[7:1] == 7'h7F) begin
         code_mask[luma[3:0]] <= 1'b1;
      end
      if (clear) begin
         code_mask <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

//--- verification/vpf_formatter_properties.sv
// Concurrent checks on the ports of the pixel output formatter
`timescale 1ns/1ps
`default_nettype none
module vpf_formatter_properties (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic full_rate_clock,
   input wire logic [15:0] pixel_bus,
   input wire logic half_rate_clock,
   input wire logic line_sync_out,
   input wire logic field_sync_out
);
   logic [7:0] quiet_q;
   logic [7:0] ofc_q;
   logic [4:0] ls_q;
   logic quiet;
   // Config is trusted only once the bus has been idle long enough for the link side to apply it
   always_ff @(posedge mclk) begin
      if (!resetn || reg_wr) begin
         quiet_q <= 8'h00;
      end else if (quiet_q != 8'hFF) begin
         quiet_q <= quiet_q + 8'h01;
      end
   end
   // Shadow of the output format control register
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ofc_q <= 8'h04;
      end else if (reg_wr && reg_addr == 8'h12) begin
         ofc_q <= reg_wdata;
      end
   end
   // Line sync history, so field sync edges can be matched to line sync edges
   always_ff @(posedge full_rate_clock) begin
      if (!resetn) begin
         ls_q <= 5'h1F;
      end else begin
         ls_q <= {ls_q[3:0], line_sync_out};
      end
   end
   assign quiet = (quiet_q == 8'hFF);

   a_read_unmapped: assert property (@(posedge mclk) disable iff (!resetn)
      reg_rd && (reg_addr < 8'h12 || reg_addr > 8'h17) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_rdata_holds: assert property (@(posedge mclk) disable iff (!resetn)
      !reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");
   a_half_rate_runs: assert property (@(posedge full_rate_clock) disable iff (!resetn)
      $changed(half_rate_clock) |=> $changed(half_rate_clock)) else $error("half rate clock stalled");
   a_sync_pulse_width: assert property (@(posedge full_rate_clock) disable iff (!resetn)
      quiet && $changed(line_sync_out) |=> $stable(line_sync_out)) else $error("line sync level too short");
   a_field_after_line: assert property (@(posedge full_rate_clock) disable iff (!resetn)
      quiet && $changed(field_sync_out) |-> line_sync_out != ls_q[0] || ls_q[1] != ls_q[2] || ls_q[3] != ls_q[4])
      else $error("field sync edge not aligned to line sync");
   a_narrow_low_idle: assert property (@(posedge full_rate_clock) disable iff (!resetn)
      quiet && !ofc_q[2] |-> pixel_bus[7:0] == 8'h00) else $error("low lanes driven in narrow mode");
   a_flag_code_luma: assert property (@(posedge full_rate_clock) disable iff (!resetn)
      quiet && ofc_q[2:1] == 2'b11 && pixel_bus[7:1] == 7'h7F |-> pixel_bus[15:8] <= 8'h06)
      else $error("code word carries bad event");
   a_std_levels: assert property (@(posedge full_rate_clock) disable iff (!resetn)
      quiet && ofc_q[2:0] == 3'b100 |-> pixel_bus[15:8] inside {[8'h10:8'hEB]} && pixel_bus[7:0] inside {[8'h02:8'hFD]})
      else $error("level outside standard range");
   a_code_levels: assert property (@(posedge full_rate_clock) disable iff (!resetn)
      quiet && ofc_q[2:0] == 3'b111 && pixel_bus[7:0] < 8'hFE |-> pixel_bus[15:8] inside {[8'h10:8'hFD]}
      && pixel_bus[7:0] >= 8'h02) else $error("video word outside coded range");
   c_line_sync: cover property (@(posedge full_rate_clock) quiet && $fell(line_sync_out));
   c_code_word: cover property (@(posedge full_rate_clock) quiet && ofc_q[1] && pixel_bus[7:0] == 8'hFF);
   c_narrow: cover property (@(posedge full_rate_clock) quiet && !ofc_q[2] && pixel_bus[15:8] != 8'h00);
endmodule
`default_nettype wire

//--- verification/vpf_formatter_test.sv
// Self-checking bench for the pixel output formatter
`timescale 1ns/1ps
`default_nettype none
module vpf_formatter_test;
   localparam int HD = 4;
   localparam int HA = 8;
   localparam logic [7:0] RA [6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h30};
   localparam logic [7:0] RV [6] = '{8'h04, 8'h00, 8'h80, 8'hD0, 8'h08, 8'h00};
   localparam logic [7:0] OF [4] = '{8'h04, 8'h01, 8'h07, 8'h03};
   localparam logic [7:0] PL [4] = '{8'h00, 8'h1F, 8'h00, 8'h0A};
   logic mclk = 1'b0;
   logic full_rate_clock = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   vpf_pkg::vpf_pixel_type src_pixel = '0;
   vpf_pkg::vpf_timing_type src_timing = '0;
   logic [15:0] pixel_bus;
   logic half_rate_clock, line_sync_out, field_sync_out, active_out, field_id_out;
   logic cap_clr = 1'b0;
   logic [15:0] cap_mask;
   logic [15:0] exp_mask = 16'h0000;
   logic run = 1'b0, chk = 1'b0, wide = 1'b1, code = 1'b0, rng = 1'b0, fpend = 1'b0, fid = 1'b0, ph = 1'b1;
   logic lpend = 1'b0;
   logic [7:0] pol = 8'h00, y, c;
   int num_errors = 0;
   int n_tests = 0;
   int h = 0, line = 0, nfield = 0, fdue = -1, nfs = 0;

   vpf_formatter uut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .full_rate_clock(full_rate_clock), .src_pixel(src_pixel),
      .src_timing(src_timing), .pixel_bus(pixel_bus), .half_rate_clock(half_rate_clock),
      .line_sync_out(line_sync_out), .field_sync_out(field_sync_out), .active_out(active_out),
      .field_id_out(field_id_out));
   vpf_capture_model far_end (.clk(full_rate_clock), .clear(cap_clr), .wide(wide), .pixel_bus(pixel_bus),
      .half_rate_clock(half_rate_clock), .code_mask(cap_mask));

   // Clocks; the link clock is offset so its edges never coincide with mclk edges
   initial begin
      forever #4 mclk = ~mclk;
   end
   initial begin
      #37;
      forever #80 full_rate_clock = ~full_rate_clock;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // Wait for the snapshot to cross, then let a few pixels pass under the new setting
   task automatic settle();
      logic [7:0] s;
      s = 8'h02;
      for (int k = 0; k < 200 && s[1] !== 1'b0; k++) reg_rd8(8'h17, s);
      check({15'h0000, s[1]}, 16'h0000);
      repeat (16) @(posedge full_rate_clock);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Source stream and reference model advance together on every pixel tick
   always @(posedge full_rate_clock) begin
      logic ls, vb, hact, on;
      logic [7:0] ev, ylo, yhi;
      if (half_rate_clock === 1'b1) begin
         on = chk;
         ls = src_timing.line_start;
         vb = src_timing.vblank;
         if (ls) ph = 1'b1;
         hact = h >= HD && h < HD + HA;
         // Separate-sync mode sends video for every pixel inside the window outside vblank, valid or not
         y = (hact && !vb) ? src_pixel.y : (rng ? 8'h00 : 8'h10);
         c = (hact && !vb) ? (ph ? src_pixel.cb : src_pixel.cr) : 8'h80;
         ylo = (rng && !code) ? 8'h00 : 8'h10;
         yhi = rng ? (code ? 8'hFD : 8'hFF) : 8'hEB;
         y = (y < ylo) ? ylo : (y > yhi) ? yhi : y;
         c = (c < 8'h02) ? 8'h02 : (c > 8'hFD) ? 8'hFD : c;
         ev = 8'hFF;
         if (src_timing.field_start) ev = src_timing.even_next ? 8'h05 : 8'h06;
         else if (ls || lpend) ev = vb ? 8'h04 : 8'h03;
         else if (!src_pixel.valid) ev = 8'h00;
         else if (h + 1 == HD) ev = 8'h02;
         else if (h == HD + HA) ev = 8'h01;
         // A line code beaten by the field code goes out on the next pixel
         if (code) lpend = ls && src_timing.field_start;
         // Invalid pixels flag the phase of the last valid one, the others their own
         if (code && ev != 8'hFF) begin
            c = (ph ^ (ev == 8'h00)) ? 8'hFF : 8'hFE;
            y = ev;
            if (on) exp_mask[ev] = 1'b1;
         end
         if (fpend && h == HD + HA) begin
            fid = !fid;
            fpend = 1'b0;
         end
         if (src_timing.field_start) fpend = 1'b1;
         // Field sync of the first, third... field waits two output clocks after line sync
         if (fdue >= 0) fdue--;
         if (src_timing.field_start) begin
            fdue = (nfs % 2 == 0) ? (wide ? 2 : 1) : 0;
            nfs++;
         end
         if (src_pixel.valid) ph = !ph;
         h = (h + 1) % 16;
         if (h == 0) line = (line + 1) % 6;
         if (h == 0 && line == 0) nfield++;
         src_pixel <= {8'($urandom), 8'($urandom), 8'($urandom), h == 0 || h == 2 || $urandom % 6 != 0};
         // Field start coincides with a line start, as the source delivers it
         src_timing <= {run && h == 0, run && line == 0 && h == 0, line < 2, nfield[0]};
         #1;
         if (on) check(pixel_bus, wide ? {y, c} : {c, 8'h00});
         if (on) check({15'h0000, active_out}, {15'h0000, (pol[4] ? hact : hact && !vb) ^ pol[0]});
         @(posedge full_rate_clock);
         #1;
         if (on && !wide) check(pixel_bus, {y, 8'h00});
         if (on) check({14'h0000, line_sync_out, field_id_out}, {14'h0000, ~ls ^ pol[1], fid ^ pol[3]});
         if (on) check({15'h0000, field_sync_out}, {15'h0000, (fdue != 0) ^ pol[2]});
      end
   end

   initial begin
      logic [7:0] d;
      void'($urandom(87));
      repeat (20) @(posedge mclk);
      repeat (4) @(posedge full_rate_clock);
      @(posedge mclk);
      resetn <= 1'b1;
      // Reset values, and an unmapped place that ignores writes
      reg_wr8(8'h30, 8'h5A);
      for (int i = 0; i < 6; i++) begin
         reg_rd8(RA[i], d);
         check({8'h00, d}, {8'h00, RV[i]});
      end
      $display("test registers done");
      reg_wr8(8'h14, 8'(HD));
      reg_wr8(8'h15, 8'(HA));
      reg_wr8(8'h16, 8'h00);
      settle();
      run = 1'b1;
      repeat (64) @(posedge full_rate_clock);
      // Wide and narrow, separate sync and coded timing, each under a polarity set
      for (int t = 0; t < 4; t++) begin
         reg_wr8(8'h12, OF[t]);
         reg_wr8(8'h13, PL[t]);
         settle();
         wide = OF[t][2];
         code = OF[t][1];
         rng = OF[t][0];
         pol = PL[t];
         exp_mask = 16'h0000;
         @(posedge full_rate_clock) cap_clr <= 1'b1;
         @(posedge full_rate_clock) cap_clr <= 1'b0;
         chk = 1'b1;
         repeat (14 * 32) @(posedge full_rate_clock);
         chk = 1'b0;
         repeat (4) @(posedge full_rate_clock);
         if (code) check(cap_mask, exp_mask);
         $display("test mode %0d done", t);
      end
      summarize();
   end

   // Tests need about half of this span
   initial begin
      #700000;
      num_errors++;
      $display("watchdog expired");
      summarize();
   end
endmodule

bind vpf_formatter vpf_formatter_properties chk_i (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .full_rate_clock, .pixel_bus, .half_rate_clock, .line_sync_out, .field_sync_out);
`default_nettype wire
